// ==== design/pbm_top.sv ====
// module: pci bus master framing, config select and interrupt pin
`timescale 1ns/1ps
module pbm_top import pbm_pkg::*; #(
	parameter int IRQ_W = IRQ_W_DEF,
	parameter int LEN_W = LEN_W_DEF
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic FRAME_N_IN,
	output logic FRAME_N_OUT,
	output logic FRAME_OE_OUT,
	input wire logic IRDY_N_IN,
	output logic IRDY_N_OUT,
	output logic IRDY_OE_OUT,
	input wire logic TRDY_N_IN,
	input wire logic DEVSEL_N_IN,
	input wire logic GNT_N_IN,
	output logic REQ_N_OUT,
	input wire logic IDSEL_IN,
	input wire logic [31:0] AD_IN,
	output logic [31:0] AD_OUT,
	output logic AD_OE_OUT,
	input wire logic [3:0] CBE_N_IN,
	output logic [3:0] CBE_N_OUT,
	output logic CBE_OE_OUT,
	output logic INT_N_OUT,
	output logic INT_OE_OUT,
	input wire logic MST_START_IN,
	input wire logic [31:0] MST_ADDR_IN,
	input wire logic [3:0] MST_CMD_IN,
	input wire logic MST_WRITE_IN,
	input wire logic [LEN_W-1:0] MST_LEN_IN,
	output logic MST_BUSY_OUT,
	output logic MST_DONE_OUT,
	output logic MST_ABORT_OUT,
	input wire logic [31:0] WR_DATA_IN,
	input wire logic WR_VALID_IN,
	output logic WR_READY_OUT,
	output logic [31:0] RD_DATA_OUT,
	output logic RD_VALID_OUT,
	input wire logic RD_READY_IN,
	output logic CFG_SEL_OUT,
	output logic CFG_WRITE_OUT,
	output logic [5:0] CFG_REG_OUT,
	input wire logic [IRQ_W-1:0] IRQ_EVENT_IN,
	input wire logic [IRQ_W-1:0] IRQ_MASK_IN,
	input wire logic IRQ_ACK_WE_IN,
	input wire logic [IRQ_W-1:0] IRQ_ACK_DATA_IN,
	output logic [IRQ_W-1:0] IRQ_STATUS_OUT
);
	pbm_state_t st_q;
	pbm_state_t st_d;
	logic [LEN_W-1:0] cnt_q;
	logic [LEN_W-1:0] cnt_d;
	logic [31:0] addr_q;
	logic [31:0] addr_d;
	logic [3:0] cmd_q;
	logic [3:0] cmd_d;
	logic wr_q;
	logic wr_d;
	logic [2:0] dsel_cnt_q;
	logic [2:0] dsel_cnt_d;
	logic dsel_seen_q;
	logic dsel_seen_d;
	logic req_n_q;
	logic req_n_d;
	logic frame_n_q;
	logic frame_n_d;
	logic frame_oe_q;
	logic frame_oe_d;
	logic irdy_n_q;
	logic irdy_n_d;
	logic irdy_oe_q;
	logic irdy_oe_d;
	logic [31:0] ad_q;
	logic [31:0] ad_d;
	logic ad_oe_q;
	logic ad_oe_d;
	logic [3:0] cbe_q;
	logic [3:0] cbe_d;
	logic cbe_oe_q;
	logic cbe_oe_d;
	logic [31:0] rd_data_q;
	logic [31:0] rd_data_d;
	logic rd_valid_q;
	logic rd_valid_d;
	logic done_q;
	logic done_d;
	logic abort_q;
	logic abort_d;
	logic frame_prev_q;
	logic cfg_sel_q;
	logic cfg_sel_d;
	logic cfg_wr_q;
	logic cfg_wr_d;
	logic [5:0] cfg_reg_q;
	logic [5:0] cfg_reg_d;
	logic irdy_act;
	logic xfer;
	logic dsel_ok;
	logic abort_now;
	logic slot_free;
	logic load;

	pbm_irq_if #(.W(IRQ_W)) irq_if ();

	assign irq_if.set_ev = IRQ_EVENT_IN;
	assign irq_if.mask = IRQ_MASK_IN;
	assign irq_if.ack_we = IRQ_ACK_WE_IN;
	assign irq_if.ack_data = IRQ_ACK_DATA_IN;

	pbm_irq #(.W(IRQ_W)) u_irq (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.bus(irq_if.unit)
	);

	// bus pins are synchronous to this clock, so no synchroniser
	assign irdy_act = irdy_oe_q && !irdy_n_q;
	assign xfer = irdy_act && !TRDY_N_IN && !DEVSEL_N_IN;
	assign dsel_ok = dsel_seen_q || !DEVSEL_N_IN;
	assign abort_now = (st_q == ST_DATA) && !dsel_ok && (dsel_cnt_q == DEVSEL_LIMIT);
	assign slot_free = (st_q == ST_DATA) && (cnt_q != '0) && (!irdy_act || xfer) && !abort_now;
	// irdy goes low only with a write word or a read slot in hand, or in the master abort cycle
	assign load = slot_free && (wr_q ? WR_VALID_IN : RD_READY_IN);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		cmd_d = cmd_q;
		wr_d = wr_q;
		dsel_cnt_d = dsel_cnt_q;
		dsel_seen_d = dsel_seen_q || ((st_q == ST_DATA) && !DEVSEL_N_IN);
		req_n_d = req_n_q;
		frame_n_d = frame_n_q;
		frame_oe_d = frame_oe_q;
		irdy_n_d = irdy_n_q;
		irdy_oe_d = irdy_oe_q;
		ad_d = ad_q;
		ad_oe_d = ad_oe_q;
		cbe_d = cbe_q;
		cbe_oe_d = cbe_oe_q;
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		done_d = 1'b0;
		abort_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (MST_START_IN) begin
					addr_d = MST_ADDR_IN;
					cmd_d = MST_CMD_IN;
					wr_d = MST_WRITE_IN;
					cnt_d = (MST_LEN_IN == '0) ? LEN_W'(1) : MST_LEN_IN;
					req_n_d = 1'b0;
					st_d = ST_REQ;
				end
			end
			ST_REQ: begin
				// wait for grant and an idle bus before driving
				if (!GNT_N_IN && FRAME_N_IN && IRDY_N_IN) begin
					req_n_d = 1'b1;
					frame_oe_d = 1'b1;
					frame_n_d = 1'b0;
					ad_d = addr_q;
					ad_oe_d = 1'b1;
					cbe_d = cmd_q;
					cbe_oe_d = 1'b1;
					dsel_cnt_d = DEVSEL_CNT_ADDR;
					dsel_seen_d = 1'b0;
					st_d = ST_ADDR;
				end
			end
			ST_ADDR: begin
				ad_oe_d = wr_q;
				cbe_d = CBE_ALL_N;
				irdy_oe_d = 1'b1;
				irdy_n_d = 1'b1;
				dsel_cnt_d = dsel_cnt_q + 3'h1;
				st_d = ST_DATA;
			end
			ST_DATA: begin
				if (abort_now) begin
					// master abort: frame up, irdy low for one cycle
					frame_n_d = 1'b1;
					irdy_n_d = 1'b0;
					ad_oe_d = 1'b0;
					abort_d = 1'b1;
					st_d = ST_ABORT;
				end else begin
					if (!dsel_ok) begin
						dsel_cnt_d = dsel_cnt_q + 3'h1;
					end
					if (xfer) begin
						irdy_n_d = 1'b1;
						if (!wr_q) begin
							rd_data_d = AD_IN;
							rd_valid_d = 1'b1;
						end
						if (cnt_q == '0) begin
							frame_oe_d = 1'b0;
							ad_oe_d = 1'b0;
							cbe_oe_d = 1'b0;
							done_d = 1'b1;
							st_d = ST_TURN;
						end
					end
					if (load) begin
						cnt_d = cnt_q - LEN_W'(1);
						irdy_n_d = 1'b0;
						if (wr_q) begin
							ad_d = WR_DATA_IN;
						end
						// release frame with the last word in hand
						if (cnt_q == LEN_W'(1)) begin
							frame_n_d = 1'b1;
						end
					end
				end
			end
			ST_ABORT: begin
				irdy_n_d = 1'b1;
				frame_oe_d = 1'b0;
				cbe_oe_d = 1'b0;
				st_d = ST_TURN;
			end
			ST_TURN: begin
				irdy_oe_d = 1'b0;
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_comb begin
		// address phase of a type 0 config cycle while idsel is high
		cfg_sel_d = frame_prev_q && !FRAME_N_IN && IDSEL_IN && !frame_oe_q
			&& (CBE_N_IN[3:1] == CFG_CMD_TOP) && (AD_IN[1:0] == CFG_TYPE0);
		cfg_wr_d = CBE_N_IN[0];
		cfg_reg_d = AD_IN[CFG_REG_MSB:CFG_REG_LSB];
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			addr_q <= AD_RST;
			cmd_q <= CBE_RST;
			wr_q <= 1'b0;
			dsel_cnt_q <= DEVSEL_CNT_RST;
			dsel_seen_q <= 1'b0;
			req_n_q <= 1'b1;
			frame_n_q <= 1'b1;
			frame_oe_q <= 1'b0;
			irdy_n_q <= 1'b1;
			irdy_oe_q <= 1'b0;
			ad_q <= AD_RST;
			ad_oe_q <= 1'b0;
			cbe_q <= CBE_RST;
			cbe_oe_q <= 1'b0;
			rd_data_q <= AD_RST;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			frame_prev_q <= 1'b1;
			cfg_sel_q <= 1'b0;
			cfg_wr_q <= 1'b0;
			cfg_reg_q <= 6'h00;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			cmd_q <= cmd_d;
			wr_q <= wr_d;
			dsel_cnt_q <= dsel_cnt_d;
			dsel_seen_q <= dsel_seen_d;
			req_n_q <= req_n_d;
			frame_n_q <= frame_n_d;
			frame_oe_q <= frame_oe_d;
			irdy_n_q <= irdy_n_d;
			irdy_oe_q <= irdy_oe_d;
			ad_q <= ad_d;
			ad_oe_q <= ad_oe_d;
			cbe_q <= cbe_d;
			cbe_oe_q <= cbe_oe_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			done_q <= done_d;
			abort_q <= abort_d;
			frame_prev_q <= FRAME_N_IN;
			cfg_sel_q <= cfg_sel_d;
			cfg_wr_q <= cfg_wr_d;
			cfg_reg_q <= cfg_reg_d;
		end
	end

	assign FRAME_N_OUT = frame_n_q;
	assign FRAME_OE_OUT = frame_oe_q;
	assign IRDY_N_OUT = irdy_n_q;
	assign IRDY_OE_OUT = irdy_oe_q;
	assign REQ_N_OUT = req_n_q;
	assign AD_OUT = ad_q;
	assign AD_OE_OUT = ad_oe_q;
	assign CBE_N_OUT = cbe_q;
	assign CBE_OE_OUT = cbe_oe_q;
	// open drain: only ever pulls low, pull-up lives on the board
	assign INT_N_OUT = 1'b0;
	assign INT_OE_OUT = irq_if.irq;
	assign IRQ_STATUS_OUT = irq_if.status;
	assign MST_BUSY_OUT = (st_q != ST_IDLE);
	assign MST_DONE_OUT = done_q;
	assign MST_ABORT_OUT = abort_q;
	assign WR_READY_OUT = slot_free && wr_q;
	assign RD_DATA_OUT = rd_data_q;
	assign RD_VALID_OUT = rd_valid_q;
	assign CFG_SEL_OUT = cfg_sel_q;
	assign CFG_WRITE_OUT = cfg_wr_q;
	assign CFG_REG_OUT = cfg_reg_q;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	sequence s_no_devsel;
		(st_q == ST_DATA) && (dsel_cnt_q == DEVSEL_LIMIT) && DEVSEL_N_IN && !dsel_seen_q;
	endsequence
	sequence s_rd_take;
		(st_q == ST_DATA) && !wr_q && (cnt_q != '0) && !irdy_act && RD_READY_IN && !abort_now;
	endsequence

	a_frame_open_addr: assert property ($rose(frame_oe_q) |-> !frame_n_q && ad_oe_q ##1 st_q == ST_DATA)
		else $error("transaction opened without frame low and address driven");
	a_frame_last_phase: assert property (
		frame_oe_q && $rose(frame_n_q) && (st_q == ST_DATA) |-> irdy_act && (cnt_q == '0))
		else $error("frame released before the final data phase");
	a_grant_before: assert property ($rose(frame_oe_q) |-> $past(GNT_N_IN) == 1'b0)
		else $error("transaction started without grant");
	a_cfg_idsel_hit: assert property (cfg_sel_q |-> $past(IDSEL_IN) && $past(frame_prev_q))
		else $error("config select without idsel");
	a_data_both_rdy: assert property (
		rd_valid_q |-> $past(irdy_act) && ($past(TRDY_N_IN) == 1'b0))
		else $error("read word taken without irdy and trdy together");
	a_wr_data_driven: assert property (irdy_act && wr_q && (st_q == ST_DATA) |-> ad_oe_q)
		else $error("write irdy without data driven");
	a_rd_irdy_ready: assert property (s_rd_take |=> irdy_act)
		else $error("read ready not shown on irdy");
	a_devsel_abort: assert property (s_no_devsel |=> st_q == ST_ABORT ##1 st_q == ST_TURN)
		else $error("missing devsel did not abort in time");
	a_req_before: assert property ($rose(frame_oe_q) |-> $past(req_n_q) == 1'b0)
		else $error("transaction started without request");
endmodule // pbm_top

// ==== pkg/pbm_pkg.sv ====
// package: constants and types for the pci bus master and interrupt block
// Functional notes
// - master drives frame low to open every transaction it starts
// - frame held low while more data follows; released as the final data phase starts
// - configuration access is ours only while idsel is high
// - interrupt asserted when a status bit is set and its mask bit is clear
// - writing one clears a status bit; request drops when none enabled remain
// - partial acknowledge drops the request one cycle, then reasserts it
// - data phase completes only on an edge with irdy and trdy both low
// - on master writes irdy is low only while write data is driven; the master abort cycle drives irdy low with AD_OE_OUT low
// - on master reads irdy low means ready to accept the target's word; the master abort cycle drives irdy low without RD_READY_IN
// - no devsel within 5 bus cycles makes the master abort the cycle
// - request line asserted before any master transaction starts
// - every bus signal sampled on the rising clock edge
package pbm_pkg;
	localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
	localparam logic [2:0] DEVSEL_CNT_RST = 3'h0;
	localparam logic [2:0] DEVSEL_CNT_ADDR = 3'h1;
	localparam logic [2:0] CFG_CMD_TOP = 3'h5;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam int CFG_REG_LSB = 2;
	localparam int CFG_REG_MSB = 7;
	localparam logic [3:0] CBE_ALL_N = 4'h0;
	localparam logic [3:0] CBE_RST = 4'hF;
	localparam logic [31:0] AD_RST = 32'h0000_0000;
	localparam int IRQ_W_DEF = 16;
	localparam int LEN_W_DEF = 8;
	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_ABORT, ST_TURN} pbm_state_t;
endpackage

// ==== pkg/pbm_irq_if.sv ====
// interface: interrupt status and mask path between core and interrupt unit
`timescale 1ns/1ps
interface pbm_irq_if #(parameter int W = 16);
	logic [W-1:0] set_ev;
	logic [W-1:0] mask;
	logic [W-1:0] ack_data;
	logic [W-1:0] status;
	logic ack_we;
	logic irq;
	modport core (output set_ev, output mask, output ack_we, output ack_data,
		input status, input irq);
	modport unit (input set_ev, input mask, input ack_we, input ack_data,
		output status, output irq);
endinterface

// ==== design/pbm_irq.sv ====
// module: interrupt status bits, mask gating and request line timing
`timescale 1ns/1ps
module pbm_irq import pbm_pkg::*; #(
	parameter int W = IRQ_W_DEF
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	pbm_irq_if.unit bus
);
	logic [W-1:0] status_q;
	logic [W-1:0] status_d;
	logic [W-1:0] clr;
	logic irq_q;
	logic irq_d;
	logic gap;

	always_comb begin
		clr = bus.ack_we ? bus.ack_data : '0;
		// a new event in the clearing cycle survives
		status_d = (status_q & ~clr) | bus.set_ev;
		// some cleared, enabled ones remain: force an edge
		gap = bus.ack_we && (|(status_q & clr)) && (|(status_d & ~bus.mask));
		// mask bit high blocks its source
		irq_d = (|(status_d & ~bus.mask)) && !gap;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_q <= '0;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q <= irq_d;
		end
	end

	assign bus.status = status_q;
	assign bus.irq = irq_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_partial_ack;
		bus.ack_we && (|(status_q & bus.ack_data)) && (|(status_q & ~bus.ack_data & ~bus.mask));
	endsequence

	a_irq_raise_pend: assert property (
		(|(status_q & ~bus.mask)) && !bus.ack_we |=> irq_q)
		else $error("enabled pending status did not raise the request");
	a_irq_ack_drop: assert property (
		bus.ack_we && ((status_q & ~bus.ack_data & ~bus.mask) == '0) && (bus.set_ev == '0)
		|=> !irq_q)
		else $error("request stayed after all enabled bits were acknowledged");
	a_irq_set_wins: assert property (
		(|bus.set_ev) |=> ((status_q & $past(bus.set_ev)) == $past(bus.set_ev)))
		else $error("event lost in the cycle of its clear");
	a_irq_edge_gap: assert property (
		s_partial_ack ##1 ((|(status_q & ~bus.mask)) && !bus.ack_we) |-> !irq_q ##1 irq_q)
		else $error("partial acknowledge did not give a one cycle gap");
endmodule // pbm_irq

// ==== dv/pbm_target.sv ====
// partner model: bus arbiter plus one target with wait and no-claim modes
`timescale 1ns/1ps
module pbm_target (
	input wire logic clk,
	input wire logic req_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [31:0] ad,
	input wire logic slow,
	input wire logic mute,
	output logic gnt_n,
	output logic trdy_n,
	output logic devsel_n,
	output logic [31:0] rd_ad,
	output logic rd_en
);
	logic act = 0;
	logic fp = 1;
	logic wt = 0;
	logic [31:0] got [0:63];
	int n = 0;
	initial begin
		gnt_n = 1;
		trdy_n = 1;
		devsel_n = 1;
		rd_en = 0;
		rd_ad = 32'h0;
	end
	always @(posedge clk) begin
		if (!irdy_n && !trdy_n) begin
			got[n] <= ad;
			n <= n + 1;
		end
		// idle bus ends our claim, also after an abort
		if (frame_n && irdy_n)
			act <= 0;
		else if (!frame_n && fp)
			act <= 1;
		fp <= frame_n;
	end
	always @(negedge clk) begin
		gnt_n <= req_n;
		wt <= ~wt;
		devsel_n <= !(act && !mute);
		trdy_n <= !(act && !mute && !(slow && wt));
		rd_en <= act && !mute;
		// released lines flip to the inverse each cycle, so the stale word comes back every second cycle
		rd_ad <= act ? 32'hA500_0000 + n : ~rd_ad;
	end
endmodule // pbm_target

// ==== dv/tb_top.sv ====
// testbench: user side, host config cycles and interrupt lines
`timescale 1ns/1ps
module tb_top;
	logic CLK_IN = 0, RST_N_IN = 0, MST_START_IN = 0, MST_WRITE_IN = 0;
	logic WR_VALID_IN = 0, RD_READY_IN = 0, IDSEL_IN = 0, IRQ_ACK_WE_IN = 0;
	logic h_fr = 1, slow = 0, mute = 0, oe_p = 0, gnt_p = 1, req_p = 1;
	logic [31:0] MST_ADDR_IN = 0, WR_DATA_IN = 0, h_ad = 0;
	logic [3:0] MST_CMD_IN = 0, h_cbe = 4'hF;
	logic [7:0] MST_LEN_IN = 0;
	logic [15:0] IRQ_EVENT_IN = 0, IRQ_MASK_IN = 0, IRQ_ACK_DATA_IN = 0;
	logic FRAME_N_OUT, FRAME_OE_OUT, IRDY_N_OUT, IRDY_OE_OUT, REQ_N_OUT, AD_OE_OUT;
	logic CBE_OE_OUT, INT_N_OUT, INT_OE_OUT, MST_BUSY_OUT, MST_DONE_OUT, MST_ABORT_OUT;
	logic WR_READY_OUT, RD_VALID_OUT, CFG_SEL_OUT, CFG_WRITE_OUT;
	logic TRDY_N_IN, DEVSEL_N_IN, GNT_N_IN, p_en;
	logic [31:0] AD_OUT, RD_DATA_OUT, p_ad;
	logic [3:0] CBE_N_OUT;
	logic [5:0] CFG_REG_OUT;
	logic [15:0] IRQ_STATUS_OUT;
	wire FRAME_N_IN = FRAME_OE_OUT ? FRAME_N_OUT : h_fr;
	wire IRDY_N_IN = IRDY_OE_OUT ? IRDY_N_OUT : 1'b1;
	wire [31:0] AD_IN = AD_OE_OUT ? AD_OUT : (p_en ? p_ad : h_ad);
	wire [3:0] CBE_N_IN = CBE_OE_OUT ? CBE_N_OUT : h_cbe;
	int fails = 0, n_checks = 0, ph = 0, lastf = 0, wi = 0, k;
	always #12.5 CLK_IN = ~CLK_IN;
	pbm_top u_pbm_top (.CLK_IN, .RST_N_IN, .FRAME_N_IN, .FRAME_N_OUT, .FRAME_OE_OUT,
		.IRDY_N_IN, .IRDY_N_OUT, .IRDY_OE_OUT, .TRDY_N_IN, .DEVSEL_N_IN, .GNT_N_IN,
		.REQ_N_OUT, .IDSEL_IN, .AD_IN, .AD_OUT, .AD_OE_OUT, .CBE_N_IN, .CBE_N_OUT,
		.CBE_OE_OUT, .INT_N_OUT, .INT_OE_OUT, .MST_START_IN, .MST_ADDR_IN, .MST_CMD_IN,
		.MST_WRITE_IN, .MST_LEN_IN, .MST_BUSY_OUT, .MST_DONE_OUT, .MST_ABORT_OUT,
		.WR_DATA_IN, .WR_VALID_IN, .WR_READY_OUT, .RD_DATA_OUT, .RD_VALID_OUT,
		.RD_READY_IN, .CFG_SEL_OUT, .CFG_WRITE_OUT, .CFG_REG_OUT, .IRQ_EVENT_IN,
		.IRQ_MASK_IN, .IRQ_ACK_WE_IN, .IRQ_ACK_DATA_IN, .IRQ_STATUS_OUT);
	pbm_target u_pbm_target (.clk(CLK_IN), .req_n(REQ_N_OUT), .frame_n(FRAME_N_IN),
		.irdy_n(IRDY_N_IN), .ad(AD_IN), .slow(slow), .mute(mute), .gnt_n(GNT_N_IN),
		.trdy_n(TRDY_N_IN), .devsel_n(DEVSEL_N_IN), .rd_ad(p_ad), .rd_en(p_en));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task cyc(input int c);
		repeat (c) @(negedge CLK_IN);
	endtask
	task automatic waitv(ref logic s, input logic v);
		k = 0;
		while (s !== v && k < 300) begin
			@(negedge CLK_IN);
			k++;
		end
		if (s !== v) begin
			fails++;
			wrap_up();
		end
	endtask
	// bus watch at the sampling edge, values before this edge's updates
	always @(posedge CLK_IN) begin
		if (IRDY_N_IN === 1'b0 && TRDY_N_IN === 1'b0) begin
			ph <= ph + 1;
			lastf <= lastf + (FRAME_N_IN === 1'b1);
			if (MST_WRITE_IN) chk(AD_OE_OUT, 1);
		end
		if (FRAME_OE_OUT && !oe_p) begin
			chk(FRAME_N_IN, 0);
			chk(AD_IN, MST_ADDR_IN);
			chk(CBE_N_IN, MST_CMD_IN);
			chk(gnt_p, 0);
			chk(req_p, 0);
		end
		oe_p <= FRAME_OE_OUT;
		gnt_p <= GNT_N_IN;
		req_p <= REQ_N_OUT;
		if (WR_VALID_IN && WR_READY_OUT) wi <= wi + 1;
	end
	always @(negedge CLK_IN) WR_DATA_IN <= 32'hD000_0000 + wi;
	task go(input logic w, input logic [7:0] len, input logic [3:0] cmd);
		ph = 0;
		lastf = 0;
		MST_WRITE_IN = w;
		MST_LEN_IN = len;
		MST_CMD_IN = cmd;
		MST_ADDR_IN = 32'h0000_1000;
		MST_START_IN = 1;
		cyc(1);
		MST_START_IN = 0;
	endtask
	task t_write;
		int n0, w0;
		n0 = u_pbm_target.n;
		w0 = wi;
		slow = 1;
		go(1, 8'h03, 4'h7);
		WR_VALID_IN = 1;
		waitv(MST_DONE_OUT, 1);
		WR_VALID_IN = 0;
		chk(ph, 3);
		chk(lastf, 1);
		for (int i = 0; i < 3; i++)
			chk(u_pbm_target.got[n0 + i], 32'hD000_0000 + w0 + i);
		waitv(MST_BUSY_OUT, 0);
		slow = 0;
		$display("write burst done");
	endtask
	task t_read;
		int n0, r;
		n0 = u_pbm_target.n;
		r = 0;
		go(0, 8'h02, 4'h6);
		// no readiness yet, so no word may move
		cyc(8);
		chk(u_pbm_target.n, n0);
		chk(IRDY_N_OUT, 1);
		RD_READY_IN = 1;
		k = 0;
		while (r < 2 && k < 100) begin
			cyc(1);
			k++;
			if (RD_VALID_OUT === 1'b1) begin
				chk(RD_DATA_OUT, 32'hA500_0000 + n0 + r);
				r++;
			end
		end
		chk(r, 2);
		RD_READY_IN = 0;
		waitv(MST_BUSY_OUT, 0);
		$display("read burst done");
	endtask
	task t_abort;
		int c;
		mute = 1;
		go(1, 8'h01, 4'h7);
		WR_VALID_IN = 1;
		waitv(FRAME_OE_OUT, 1);
		c = 0;
		while (MST_ABORT_OUT !== 1'b1 && c < 20) begin
			cyc(1);
			c++;
		end
		chk(c, 5);
		chk(ph, 0);
		WR_VALID_IN = 0;
		waitv(MST_BUSY_OUT, 0);
		mute = 0;
		$display("master abort done");
	endtask
	task t_cfg(input logic sel, input logic [3:0] cbe);
		IDSEL_IN = sel;
		h_fr = 0;
		h_cbe = cbe;
		h_ad = 32'h0000_0024;
		cyc(1);
		// select pulse stands only in the cycle after the frame edge
		chk(CFG_SEL_OUT, sel);
		if (sel) chk(CFG_REG_OUT, 6'h09);
		if (sel) chk(CFG_WRITE_OUT, cbe[0]);
		h_fr = 1;
		IDSEL_IN = 0;
		h_cbe = 4'hF;
		h_ad = 32'hFFFF_FFDB;
		cyc(1);
		chk(CFG_SEL_OUT, 0);
		cyc(2);
		$display("config select done");
	endtask
	task ack(input logic [15:0] d);
		IRQ_ACK_WE_IN = 1;
		IRQ_ACK_DATA_IN = d;
		cyc(1);
		IRQ_ACK_WE_IN = 0;
	endtask
	task t_irq;
		int lo;
		IRQ_MASK_IN = 16'h0004;
		IRQ_EVENT_IN = 16'h0004;
		cyc(1);
		IRQ_EVENT_IN = 0;
		cyc(2);
		chk(IRQ_STATUS_OUT, 16'h0004);
		chk(INT_OE_OUT, 0);
		IRQ_EVENT_IN = 16'h0003;
		cyc(1);
		IRQ_EVENT_IN = 0;
		cyc(1);
		chk(INT_OE_OUT, 1);
		chk(INT_N_OUT, 0);
		ack(16'h0001);
		lo = 0;
		repeat (5) begin
			lo += !INT_OE_OUT;
			cyc(1);
		end
		chk(lo, 1);
		chk(INT_OE_OUT, 1);
		ack(16'h0002);
		cyc(2);
		chk(INT_OE_OUT, 0);
		chk(IRQ_STATUS_OUT, 16'h0004);
		IRQ_MASK_IN = 0;
		cyc(2);
		chk(INT_OE_OUT, 1);
		ack(16'h0004);
		cyc(2);
		chk(INT_OE_OUT, 0);
		chk(IRQ_STATUS_OUT, 16'h0000);
		// event in the same cycle as its clear must survive
		IRQ_EVENT_IN = 16'h0001;
		cyc(1);
		ack(16'h0001);
		IRQ_EVENT_IN = 0;
		cyc(1);
		chk(IRQ_STATUS_OUT, 16'h0001);
		ack(16'h0001);
		cyc(1);
		chk(IRQ_STATUS_OUT, 16'h0000);
		$display("interrupt done");
	endtask
	initial begin
		cyc(16);
		RST_N_IN = 1;
		cyc(2);
		t_write();
		t_read();
		t_abort();
		t_cfg(1, 4'hA);
		t_cfg(1, 4'hB);
		t_cfg(0, 4'hA);
		t_irq();
		wrap_up();
	end
endmodule // tb_top
